// File: fpl_pkg.sv
// Package: instruction fields, opcodes, widths and carrier types for the paired load unit
package fpl_pkg;

  // ==========================================
  // Widths
  localparam int ADDR_W = 32;
  localparam int DATA_W = 64;
  localparam int REG_W  = 5;

  // ==========================================
  // Instruction field positions (bit 31 is the most significant bit)
  localparam int PRIMARY_HI = 31;
  localparam int PRIMARY_LO = 26;
  localparam int TARGET_HI  = 25;
  localparam int TARGET_LO  = 21;
  localparam int BASE_HI    = 20;
  localparam int BASE_LO    = 16;
  localparam int INDEX_HI   = 15;
  localparam int INDEX_LO   = 11;
  localparam int EXT_HI     = 10;
  localparam int EXT_LO     = 1;
  localparam int DISP_HI    = 15;
  localparam int DISP_LO    = 2;
  localparam int DISP_W     = 14;
  localparam int LOW2_HI    = 1;
  localparam int LOW2_LO    = 0;

  // ==========================================
  // Opcodes
  localparam logic [5:0] OP_INDEXED     = 6'h1F;
  localparam logic [5:0] OP_PAIR_DISP   = 6'h38;
  localparam logic [5:0] OP_PAIR_DISP_U = 6'h39;
  localparam logic [9:0] XO_DBL_UPD     = 10'h277;
  localparam logic [9:0] XO_DBL         = 10'h257;
  localparam logic [9:0] XO_PAIR_UPD    = 10'h337;
  localparam logic [1:0] LOW2_DISP      = 2'h0;
  localparam logic [ADDR_W-1:0] PAIR_STEP = 32'h0000_0008;

  // ==========================================
  // Carrier types
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
  } fpl_mem_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic              alignFault;
    logic              storageFault;
  } fpl_mem_rsp_t;

  typedef struct packed {
    logic              valid;
    logic [REG_W-1:0]  target;
    logic [DATA_W-1:0] data;
  } fpl_fpr_wr_t;

  typedef struct packed {
    logic              valid;
    logic [REG_W-1:0]  target;
    logic [ADDR_W-1:0] data;
  } fpl_gpr_wr_t;

  typedef enum logic [2:0] {
    CLS_NONE = 3'h0,
    CLS_DBL  = 3'h1,
    CLS_DBLU = 3'h2,
    CLS_PRD  = 3'h3,
    CLS_PRDU = 3'h4,
    CLS_PRXU = 3'h5
  } fpl_class_t;

  typedef struct packed {
    fpl_class_t        cls;
    logic [REG_W-1:0]  target;
    logic [REG_W-1:0]  base;
    logic [REG_W-1:0]  index;
    logic [DISP_W-1:0] disp;
    logic              recordBit;
  } fpl_decoded_t;

endpackage

// File: fpl_decode.sv
// Module: combinational decoder for the floating doubleword and paired loads
`timescale 1ns/1ns
module fpl_decode (
  // Instruction word
  input  wire logic [31:0]           instr,
  // Decoded instruction
  output fpl_pkg::fpl_decoded_t      dec
);

  logic [5:0] primary;
  logic [9:0] extended;
  logic [1:0] low2;

  always_comb begin
    primary       = instr[fpl_pkg::PRIMARY_HI:fpl_pkg::PRIMARY_LO];
    extended      = instr[fpl_pkg::EXT_HI:fpl_pkg::EXT_LO];
    low2          = instr[fpl_pkg::LOW2_HI:fpl_pkg::LOW2_LO];
    dec.target    = instr[fpl_pkg::TARGET_HI:fpl_pkg::TARGET_LO];
    dec.base      = instr[fpl_pkg::BASE_HI:fpl_pkg::BASE_LO];
    dec.index     = instr[fpl_pkg::INDEX_HI:fpl_pkg::INDEX_LO];
    dec.disp      = instr[fpl_pkg::DISP_HI:fpl_pkg::DISP_LO];
    dec.recordBit = instr[0];
    dec.cls       = fpl_pkg::CLS_NONE;
    if (primary == fpl_pkg::OP_INDEXED) begin
      if (extended == fpl_pkg::XO_DBL_UPD) begin
        dec.cls = fpl_pkg::CLS_DBLU;
      end else if (extended == fpl_pkg::XO_DBL) begin
        dec.cls = fpl_pkg::CLS_DBL;
      end else if (extended == fpl_pkg::XO_PAIR_UPD) begin
        dec.cls = fpl_pkg::CLS_PRXU;
      end
    end else if (primary == fpl_pkg::OP_PAIR_DISP && low2 == fpl_pkg::LOW2_DISP) begin
      dec.cls = fpl_pkg::CLS_PRD;
    end else if (primary == fpl_pkg::OP_PAIR_DISP_U && low2 == fpl_pkg::LOW2_DISP) begin
      dec.cls = fpl_pkg::CLS_PRDU;
    end
  end

endmodule

// File: fpl_load_unit.sv
// Module: floating doubleword and paired doubleword load execution unit
// How it works
// - Update-indexed double: op 31, ext 631
// - Indexed address: base plus index, or index
// - Update base only if nonzero and faultless
// - Update-indexed double leaves status register alone
// - Plain indexed double: op 31, ext 599
// - Plain indexed double writes no base, flags
// - Paired displacement load: op 56, low 00
// - Displacement sign-extended, two zero bits appended
// - Displacement address: offset, or base plus offset
// - Pair: target then next, 31 wraps 0
// - Paired displacement update: op 57, low 00
// - Paired updates write address to nonzero base
// - Paired indexed update: op 31, ext 823
// - Paired indexed address: base plus index, or index
// - Paired loads leave status and field 0
`timescale 1ns/1ns
module fpl_load_unit (
  // Clock, reset, enable
  input  wire logic                        ref_clk,
  input  wire logic                        rstn,
  input  wire logic                        clkEn,
  // Instruction issue
  input  wire logic                        issueValid,
  input  wire logic [31:0]                 instr,
  output logic                             issueReady,
  // General register read port values for base and index fields
  input  wire logic [fpl_pkg::ADDR_W-1:0]  baseValue,
  input  wire logic [fpl_pkg::ADDR_W-1:0]  indexValue,
  // Paired-load support strap
  input  wire logic                        pairEnable,
  // Memory request
  output logic                             memReqValid,
  output fpl_pkg::fpl_mem_req_t            memReq,
  input  wire logic                        memReqReady,
  // Memory response
  input  wire logic                        memRspValid,
  input  fpl_pkg::fpl_mem_rsp_t            memRsp,
  // Register writes
  output fpl_pkg::fpl_fpr_wr_t             floatWr0,
  output fpl_pkg::fpl_fpr_wr_t             floatWr1,
  output fpl_pkg::fpl_gpr_wr_t             generalWr,
  // Completion
  output logic                             doneValid,
  output logic                             illegalInstr,
  output logic                             faultReport
);

  // ==========================================
  // Decode
  fpl_pkg::fpl_decoded_t dec;

  fpl_decode uDecode (
    .instr (instr),
    .dec   (dec)
  );

  // ==========================================
  // State machine
  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_REQ0  = 5'h02,
    ST_REQ1  = 5'h04,
    ST_WAIT  = 5'h08,
    ST_DONE  = 5'h10
  } fpl_state_t;

  fpl_state_t                   state_reg, state_next;
  fpl_pkg::fpl_class_t          cls_reg, cls_next;
  logic [fpl_pkg::REG_W-1:0]    target_reg, target_next;
  logic [fpl_pkg::REG_W-1:0]    base_reg, base_next;
  logic [fpl_pkg::ADDR_W-1:0]   ea_reg, ea_next;
  logic [fpl_pkg::ADDR_W-1:0]   memAddr_reg, memAddr_next;
  logic [fpl_pkg::DATA_W-1:0]   data0_reg, data0_next;
  logic [fpl_pkg::DATA_W-1:0]   data1_reg, data1_next;
  logic [1:0]                   rspCount_reg, rspCount_next;
  logic                         fault_reg, fault_next;
  logic                         memReqValid_reg, memReqValid_next;
  fpl_pkg::fpl_fpr_wr_t         floatWr0_reg, floatWr0_next;
  fpl_pkg::fpl_fpr_wr_t         floatWr1_reg, floatWr1_next;
  fpl_pkg::fpl_gpr_wr_t         generalWr_reg, generalWr_next;
  logic                         done_reg, done_next;
  logic                         illegal_reg, illegal_next;
  logic                         faultOut_reg, faultOut_next;
  logic                         issueReady_reg, issueReady_next;

  // ==========================================
  // Effective address and control terms
  logic [fpl_pkg::ADDR_W-1:0]   dispOffset;
  logic [fpl_pkg::ADDR_W-1:0]   addrBase;
  logic [fpl_pkg::ADDR_W-1:0]   addrTerm;
  logic                         isPair;
  logic                         isUpdate;
  logic                         wantsBase;
  logic                         needsTwo;
  logic                         rspFault;
  logic                         takeIssue;
  logic                         rejectIssue;

  always_comb begin
    // Sign-extend to 30 bits, then two zero bits
    dispOffset = {{(fpl_pkg::ADDR_W - fpl_pkg::DISP_W - 2){dec.disp[fpl_pkg::DISP_W-1]}},
                  dec.disp, 2'h0};
    addrBase   = (dec.base != '0) ? baseValue : '0;
    addrTerm   = (dec.cls == fpl_pkg::CLS_PRD || dec.cls == fpl_pkg::CLS_PRDU)
                 ? dispOffset : indexValue;
    isPair     = (dec.cls == fpl_pkg::CLS_PRD) || (dec.cls == fpl_pkg::CLS_PRDU)
                 || (dec.cls == fpl_pkg::CLS_PRXU);
    isUpdate   = (dec.cls == fpl_pkg::CLS_DBLU) || (dec.cls == fpl_pkg::CLS_PRDU)
                 || (dec.cls == fpl_pkg::CLS_PRXU);
    wantsBase  = isUpdate && (dec.base != '0);
    takeIssue   = issueValid && issueReady_reg;
    rejectIssue = (dec.cls == fpl_pkg::CLS_NONE) || (isPair && !pairEnable);
    needsTwo   = (cls_reg == fpl_pkg::CLS_PRD) || (cls_reg == fpl_pkg::CLS_PRDU)
                 || (cls_reg == fpl_pkg::CLS_PRXU);
    rspFault   = memRsp.alignFault || memRsp.storageFault;
  end

  always_comb begin
    state_next       = state_reg;
    cls_next         = cls_reg;
    target_next      = target_reg;
    base_next        = base_reg;
    ea_next          = ea_reg;
    memAddr_next     = memAddr_reg;
    memReqValid_next = memReqValid_reg;
    issueReady_next  = issueReady_reg;
    case (state_reg)
      ST_IDLE: begin
        if (takeIssue && !rejectIssue) begin
          cls_next         = dec.cls;
          target_next      = dec.target;
          base_next        = wantsBase ? dec.base : '0;
          ea_next          = addrBase + addrTerm;
          memAddr_next     = addrBase + addrTerm;
          memReqValid_next = 1'b1;
          issueReady_next  = 1'b0;
          state_next       = ST_REQ0;
        end
      end
      ST_REQ0: begin
        if (memReqReady) begin
          // Second doubleword sits eight bytes above the first
          memAddr_next     = ea_reg + fpl_pkg::PAIR_STEP;
          memReqValid_next = needsTwo;
          state_next       = needsTwo ? ST_REQ1 : ST_WAIT;
        end
      end
      ST_REQ1: begin
        if (memReqReady) begin
          memReqValid_next = 1'b0;
          state_next       = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if ((needsTwo && rspCount_reg == 2'h2) || (!needsTwo && rspCount_reg == 2'h1)) begin
          state_next = ST_DONE;
        end
      end
      ST_DONE: begin
        issueReady_next = 1'b1;
        state_next      = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      state_reg       <= ST_IDLE;
      cls_reg         <= fpl_pkg::CLS_NONE;
      target_reg      <= '0;
      base_reg        <= '0;
      ea_reg          <= '0;
      memAddr_reg     <= '0;
      memReqValid_reg <= 1'b0;
      issueReady_reg  <= 1'b1;
    end else if (clkEn) begin
      state_reg       <= state_next;
      cls_reg         <= cls_next;
      target_reg      <= target_next;
      base_reg        <= base_next;
      ea_reg          <= ea_next;
      memAddr_reg     <= memAddr_next;
      memReqValid_reg <= memReqValid_next;
      issueReady_reg  <= issueReady_next;
    end
  end

  // ==========================================
  // Response capture
  always_comb begin
    data0_next    = data0_reg;
    data1_next    = data1_reg;
    rspCount_next = rspCount_reg;
    fault_next    = fault_reg;
    if (state_reg == ST_IDLE && takeIssue) begin
      rspCount_next = 2'h0;
      fault_next    = 1'b0;
    end
    // Responses return in request order and may overlap the request phase
    if (memRspValid && state_reg != ST_IDLE && state_reg != ST_DONE) begin
      if (rspCount_reg == 2'h0) begin
        data0_next = memRsp.data;
      end else begin
        data1_next = memRsp.data;
      end
      rspCount_next = rspCount_reg + 2'h1;
      fault_next    = fault_reg | rspFault;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      data0_reg    <= '0;
      data1_reg    <= '0;
      rspCount_reg <= 2'h0;
      fault_reg    <= 1'b0;
    end else if (clkEn) begin
      data0_reg    <= data0_next;
      data1_reg    <= data1_next;
      rspCount_reg <= rspCount_next;
      fault_reg    <= fault_next;
    end
  end

  // ==========================================
  // Completion pulses and register writes
  always_comb begin
    floatWr0_next  = '0;
    floatWr1_next  = '0;
    generalWr_next = '0;
    done_next      = 1'b0;
    illegal_next   = 1'b0;
    faultOut_next  = 1'b0;
    if (state_reg == ST_IDLE && takeIssue && rejectIssue) begin
      illegal_next = 1'b1;
      done_next    = 1'b1;
    end
    if (state_reg == ST_DONE) begin
      // Nothing touches status or condition field; no such outputs exist
      if (!fault_reg) begin
        floatWr0_next  = '{valid: 1'b1, target: target_reg, data: data0_reg};
        floatWr1_next  = '{valid: needsTwo, target: target_reg + 5'h01,
                           data: data1_reg};
        generalWr_next = '{valid: (base_reg != '0), target: base_reg,
                           data: ea_reg};
      end
      faultOut_next = fault_reg;
      done_next     = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      floatWr0_reg  <= '0;
      floatWr1_reg  <= '0;
      generalWr_reg <= '0;
      done_reg      <= 1'b0;
      illegal_reg   <= 1'b0;
      faultOut_reg  <= 1'b0;
    end else if (clkEn) begin
      floatWr0_reg  <= floatWr0_next;
      floatWr1_reg  <= floatWr1_next;
      generalWr_reg <= generalWr_next;
      done_reg      <= done_next;
      illegal_reg   <= illegal_next;
      faultOut_reg  <= faultOut_next;
    end
  end

  // ==========================================
  // Outputs, all straight from registers
  always_comb begin
    memReqValid  = memReqValid_reg;
    memReq.addr  = memAddr_reg;
    floatWr0     = floatWr0_reg;
    floatWr1     = floatWr1_reg;
    generalWr    = generalWr_reg;
    doneValid    = done_reg;
    illegalInstr = illegal_reg;
    faultReport  = faultOut_reg;
    issueReady   = issueReady_reg;
  end

endmodule

// File: fpl_load_unit_sva.sv
// Checker: port-level properties of the paired load unit
`timescale 1ns/1ns
module fpl_load_unit_sva (
  // Clock, reset, enable
  input wire logic             ref_clk,
  input wire logic             rstn,
  input wire logic             clkEn,
  // Issue
  input wire logic             issueValid,
  input wire logic [31:0]      instr,
  input wire logic             issueReady,
  input wire logic             pairEnable,
  // Memory and results
  input wire logic             memReqValid,
  input fpl_pkg::fpl_mem_req_t memReq,
  input wire logic             memReqReady,
  input fpl_pkg::fpl_fpr_wr_t  floatWr0,
  input fpl_pkg::fpl_fpr_wr_t  floatWr1,
  input fpl_pkg::fpl_gpr_wr_t  generalWr,
  input wire logic             doneValid,
  input wire logic             illegalInstr,
  input wire logic             faultReport
);
  logic        taken;
  logic        plainReg;
  logic [1:0]  accReg;
  logic [31:0] firstReg;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  assign taken = clkEn && issueValid && issueReady;
  // ==========================================
  // Accepted requests of the current instruction
  always_ff @(posedge ref_clk) begin
    if (!rstn || taken) begin
      accReg   <= 2'h0;
      plainReg <= taken && instr[31:26] == 6'h1F && instr[10:1] == 10'h257;
    end else if (clkEn && memReqValid && memReqReady) begin
      accReg <= accReg + 2'h1;
      if (accReg == 2'h0) firstReg <= memReq.addr;
    end
  end
  // ==========================================
  // Properties
  a_issue_answer: assert property (taken |=> memReqValid || (doneValid && illegalInstr))
    else $error("issue got no answer");
  a_req_hold: assert property (memReqValid && !memReqReady |=> memReqValid && $stable(memReq))
    else $error("request dropped or changed");
  a_pair_step: assert property (memReqValid && memReqReady && accReg == 2'h1 |->
    memReq.addr == firstReg + 32'h8) else $error("second address not eight higher");
  a_pair_wrap: assert property (floatWr1.valid |-> floatWr0.valid &&
    floatWr1.target == floatWr0.target + 5'h01) else $error("pair target wrong");
  a_wr_at_done: assert property (floatWr0.valid || generalWr.valid |->
    doneValid && !illegalInstr && !faultReport) else $error("write outside clean done");
  a_base_is_ea: assert property (generalWr.valid |->
    generalWr.data == firstReg && generalWr.target != 5'h00) else $error("bad base write");
  a_plain_nobase: assert property (generalWr.valid |-> !plainReg)
    else $error("plain load wrote base");
  a_pair_illegal: assert property (taken && !pairEnable &&
    instr[31:26] inside {6'h38, 6'h39} |=> doneValid && illegalInstr)
    else $error("pair accepted while unsupported");
  a_done_ready: assert property (doneValid |-> issueReady) else $error("not ready at done");
endmodule
bind fpl_load_unit fpl_load_unit_sva i_sva (.ref_clk, .rstn, .clkEn, .issueValid, .instr,
  .issueReady, .pairEnable, .memReqValid, .memReq, .memReqReady, .floatWr0, .floatWr1,
  .generalWr, .doneValid, .illegalInstr, .faultReport);

// File: fpl_mem_model.sv
// Partner: in-order data memory path with stalls and fault injection
`timescale 1ns/1ns
module fpl_mem_model (
  // Clock and reset
  input wire logic              ref_clk,
  input wire logic              rstn,
  // Behaviour controls
  input wire logic              stall,
  input wire logic [1:0]        faultSel,
  // Request and response
  input wire logic              memReqValid,
  input fpl_pkg::fpl_mem_req_t  memReq,
  output logic                  memReqReady,
  output logic                  memRspValid,
  output fpl_pkg::fpl_mem_rsp_t memRsp
);
  logic [31:0] pend[$];
  always @(posedge ref_clk) begin
    memRspValid <= 1'b0;
    memRsp      <= ~memRsp;
    memReqReady <= !stall;
    if (!rstn) begin
      pend.delete();
      memRsp      <= '0;
      memReqReady <= 1'b0;
    end else begin
      if (memReqValid && memReqReady) pend.push_back(memReq.addr);
      // Answers in request order, data tagged with its address
      if (pend.size() > 0 && !stall) begin
        memRspValid <= 1'b1;
        memRsp      <= {pend[0], ~pend[0], faultSel};
        void'(pend.pop_front());
      end
    end
  end
endmodule

// File: tb_top.sv
// Testbench: random decode and execution of the paired load unit against a model
`timescale 1ns/1ns
module tb_top;
  logic                  ref_clk = 1'b0;
  logic                  rstn = 1'b0;
  logic                  issueValid = 1'b0;
  logic [31:0]           instr = 32'h0;
  logic [31:0]           baseValue = 32'h0;
  logic [31:0]           indexValue = 32'h0;
  logic                  pairEnable = 1'b0;
  logic                  clkEn = 1'b1;
  logic                  stall = 1'b0;
  logic [1:0]            faultSel = 2'h0;
  logic                  issueReady, memReqValid, memReqReady, memRspValid;
  logic                  doneValid, illegalInstr, faultReport;
  fpl_pkg::fpl_mem_req_t memReq;
  fpl_pkg::fpl_mem_rsp_t memRsp;
  fpl_pkg::fpl_fpr_wr_t  floatWr0, floatWr1;
  fpl_pkg::fpl_gpr_wr_t  generalWr;
  int                    err_total = 0;
  int                    checks_done = 0;
  always #10 ref_clk = ~ref_clk;
  fpl_load_unit i_dut (.ref_clk, .rstn, .clkEn, .issueValid, .instr, .issueReady,
    .baseValue, .indexValue, .pairEnable, .memReqValid, .memReq, .memReqReady, .memRspValid,
    .memRsp, .floatWr0, .floatWr1, .generalWr, .doneValid, .illegalInstr, .faultReport);
  fpl_mem_model i_mem (.ref_clk, .rstn, .stall, .faultSel, .memReqValid, .memReq,
    .memReqReady, .memRspValid, .memRsp);
  // ==========================================
  // Checking and closing
  task automatic chkW(input logic [69:0] got, input logic [69:0] exp, input string m);
    checks_done++;
    if (exp[69] ? (got !== exp) : (got[69] !== 1'b0)) begin
      err_total++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ==========================================
  // One instruction through issue, memory and completion
  task automatic run_one(input int k);
    logic [31:0] w, ea, e8;
    logic [4:0]  t, b;
    logic        pd, ill, flt, up;
    logic [1:0]  pv;
    int          n;
    w = $urandom;
    t = ($urandom % 4 == 0) ? 5'h1F : 5'($urandom);
    b = ($urandom % 4 == 0) ? 5'h00 : 5'($urandom);
    case (k)
      0: w = {6'h1F, t, b, w[15:11], 10'h257, 1'b0};
      1: w = {6'h1F, t, b, w[15:11], 10'h277, 1'b0};
      2: w = {6'h1F, t, b, w[15:11], 10'h337, w[0]};
      3: w = {6'h38, t, b, w[15:2], 2'h0};
      4: w = {6'h39, t, b, w[15:2], 2'h0};
      5: w = {5'h1C, w[26], t, b, w[15:2], w[1:0] | 2'h1};
      default: w = {6'h1F, t, b, w[15:11], 10'h317, 1'b0};
    endcase
    baseValue  = $urandom;
    indexValue = $urandom;
    pairEnable = ($urandom % 5 != 0);
    faultSel   = ($urandom % 6 == 0) ? 2'($urandom % 3 + 1) : 2'h0;
    pd  = pairEnable && (k == 3 || k == 4);
    ill = !(k < 2 || pd || (k == 2 && pairEnable));
    up  = (k == 1 || k == 2 || k == 4) && b != 5'h00;
    ea  = (b != 5'h00 ? baseValue : 32'h0) + (pd ? {{16{w[15]}}, w[15:2], 2'h0} : indexValue);
    e8  = ea + 32'h8;
    flt = faultSel != 2'h0 && !ill;
    clkEn      = ($urandom % 4 != 0);
    pv         = {doneValid, illegalInstr};
    instr      = w;
    issueValid = 1'b1;
    if (!clkEn) begin
      // Enable low: the offered issue must not be taken, nothing may move
      @(posedge ref_clk);
      #1;
      chkW({1'b1, memReqValid, issueReady, doneValid, illegalInstr, 65'h0},
           {3'h5, pv, 65'h0}, "frozen");
      clkEn = 1'b1;
    end
    @(posedge ref_clk);
    #1;
    issueValid = 1'b0;
    n = 0;
    while (doneValid !== 1'b1 && n < 100) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chkW({doneValid, illegalInstr, faultReport, 67'h0}, {1'b1, ill, flt, 67'h0},
      "flags");
    chkW(floatWr0, {!ill && !flt, t, ea, ~ea}, "float0");
    chkW(floatWr1, {!ill && !flt && k > 1, t + 5'h01, e8, ~e8}, "float1");
    chkW({generalWr.valid, 32'h0, generalWr[36:0]}, {!ill && !flt && up, 32'h0, b, ea},
      "base");
  endtask
  // ==========================================
  // Stimulus
  always @(posedge ref_clk) begin
    #1;
    stall = ($urandom % 4 == 0);
  end
  initial begin
    #100000;
    err_total++;
    end_sim();
  end
  initial begin
    void'($urandom(32'hE243));
    repeat (4) @(posedge ref_clk);
    #1;
    rstn = 1'b1;
    for (int i = 0; i < 70; i++) run_one(i % 7);
    end_sim();
  end
endmodule
